// [qec_pkg.sv]
package qec_pkg;

    // ------------------------------------------------------------
    // Widths, modes and reset values
    // ------------------------------------------------------------
    localparam int          CNT_W        = 32;
    localparam logic [31:0] CNT_RST      = 32'h0000_0000;
    localparam logic [31:0] CNT_ZERO     = 32'h0000_0000;
    localparam int          SYNC_STAGES  = 2;
    localparam logic [1:0]  IDX_PHASE    = 2'h3;

    typedef enum logic [1:0] {
        single_edge_decode = 2'b00,
        double_edge_decode = 2'b01,
        quad_edge_decode   = 2'b10,
        spare_decode       = 2'b11
    } qec_mode_e;

endpackage

// [qec_sync_if.sv]
`timescale 1ns/1ns
interface qec_sync_if;
    logic chA;
    logic chB;
    logic chZ;
    logic chAPrev;
    logic chBPrev;
    logic chZPrev;

    modport src (output chA, output chB, output chZ, output chAPrev, output chBPrev,
                 output chZPrev);
    modport dst (input chA, input chB, input chZ, input chAPrev, input chBPrev,
                 input chZPrev);
endinterface

// [qec_input_sync.sv]
`timescale 1ns/1ns
module qec_input_sync
    import qec_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pinA,
    input  wire logic pinB,
    input  wire logic pinZ,
    input  wire logic invA,
    input  wire logic invB,
    input  wire logic invZ,
    qec_sync_if.src   sync
);

    // ------------------------------------------------------------
    // Two-stage synchronisers followed by a history stage
    // ------------------------------------------------------------
    logic [2:0] meta_r;
    logic [2:0] stable_r;
    logic [2:0] prev_r;
    logic [2:0] pinVec;
    logic [2:0] invVec;
    logic [2:0] polVec;

    assign pinVec = {pinZ, pinB, pinA};
    assign invVec = {invZ, invB, invA};
    // Inversion is applied after the synchroniser so the first stage feeds only the second.
    assign polVec = stable_r ^ invVec;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r   <= 3'h0;
            stable_r <= 3'h0;
            prev_r   <= 3'h0;
        end else begin
            meta_r   <= pinVec;
            stable_r <= meta_r;
            prev_r   <= polVec;
        end
    end

    assign sync.chA     = polVec[0];
    assign sync.chB     = polVec[1];
    assign sync.chZ     = polVec[2];
    assign sync.chAPrev = prev_r[0];
    assign sync.chBPrev = prev_r[1];
    assign sync.chZPrev = prev_r[2];

endmodule

// [qec_counter.sv]
`timescale 1ns/1ns
// Summary of operation
// - Single mode, A leading B: count up on each rising edge of A.
// - Single mode, B leading A: count down on each falling edge of A.
// - Capture the position count on every sample clock.
// - Double mode: count on both edges of A, ignore B edges.
// - Double mode: up while A leads B, down while B leads A.
// - Quad mode: count every edge of A and B, same direction rule.
// - Enabled index reloads the count with zero at one quadrature phase.
// - An inverted channel swaps its rising and falling edges.
module qec_counter
    import qec_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             pinA,
    input  wire logic             pinB,
    input  wire logic             pinZ,
    input  wire logic             invA,
    input  wire logic             invB,
    input  wire logic             invZ,
    input  wire logic [1:0]       decodeMode,
    input  wire logic             indexEn,
    input  wire logic             sampleClk,
    output logic      [CNT_W-1:0] sampleCount,
    output logic                  sampleValid,
    output logic                  dirUp
);

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    qec_sync_if syncBus ();

    qec_input_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pinA     (pinA),
        .pinB     (pinB),
        .pinZ     (pinZ),
        .invA     (invA),
        .invB     (invB),
        .invZ     (invZ),
        .sync     (syncBus.src)
    );

    // The sample clock is foreign to core_clk, so it gets its own two stages.
    // Stage 3 only keeps history for the edge test and never feeds logic early.
    logic [2:0]       smpSync_r;
    logic [2:0]       smpSync_nxt;

    // ------------------------------------------------------------
    // Decode signals
    // ------------------------------------------------------------
    logic [1:0]       chNow;
    logic [1:0]       chPrev;
    logic [1:0]       chRise;
    logic [1:0]       chFall;
    logic             aRise;
    logic             aFall;
    logic             aEdge;
    logic             bEdge;
    logic             sglEvt;
    logic             sglUp;
    logic             dblEvt;
    logic             dblUp;
    logic             quadEvt;
    logic             quadUp;
    logic             countEvt;
    logic             stepUp;
    logic             idxPhase;
    logic             idxHit;
    logic             sampleEvt;
    qec_mode_e        mode;

    // ------------------------------------------------------------
    // Count and capture signals
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] countInc;
    logic [CNT_W-1:0] countDec;
    logic [CNT_W-1:0] countStep;
    logic [CNT_W-1:0] sampleCount_nxt;
    logic             sampleValid_nxt;
    logic             dirUp_nxt;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Direction from the classic quadrature transition table: a change of A
    // steps up when the new A differs from B; a change of B when it equals A.
    function automatic logic dir_of(input logic edgeOnA, input logic a, input logic b);
        dir_of = edgeOnA ? (a != b) : (a == b);
    endfunction

    // One selector serves event and direction, so the two never disagree on the mode.
    function automatic logic pick_by_mode(input qec_mode_e m,
                                          input logic      sgl,
                                          input logic      dbl,
                                          input logic      quad);
        case (m)
            single_edge_decode: begin
                pick_by_mode = sgl;
            end
            double_edge_decode: begin
                pick_by_mode = dbl;
            end
            quad_edge_decode: begin
                pick_by_mode = quad;
            end
            default: begin
                pick_by_mode = 1'b0;
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    assign chNow  = {syncBus.chB, syncBus.chA};
    assign chPrev = {syncBus.chBPrev, syncBus.chAPrev};

    // A and B share one detector shape, one copy per channel.
    // Edges are taken after inversion, so an inverted channel swaps its edges.
    generate
        for (genvar gi = 0; gi < 2; gi++) begin : g_edge
            assign chRise[gi] = chNow[gi] & ~chPrev[gi];
            assign chFall[gi] = ~chNow[gi] & chPrev[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Per-mode decode
    // ------------------------------------------------------------
    assign mode  = qec_mode_e'(decodeMode);
    assign aRise = chRise[0];
    assign aFall = chFall[0];
    assign aEdge = aRise | aFall;
    assign bEdge = chRise[1] | chFall[1];

    // Rising A with B low means A leads; falling A with B low means B leads.
    assign sglEvt  = aEdge & ~syncBus.chB;
    assign sglUp   = aRise;
    assign dblEvt  = aEdge;
    assign dblUp   = dir_of(1'b1, syncBus.chA, syncBus.chB);
    // A simultaneous A and B change is illegal for a quadrature source; it is
    // counted as an A edge only, which keeps the logic small.
    assign quadEvt = aEdge | bEdge;
    assign quadUp  = dir_of(aEdge, syncBus.chA, syncBus.chB);

    assign countEvt = pick_by_mode(mode, sglEvt, dblEvt, quadEvt);
    assign stepUp   = pick_by_mode(mode, sglUp, dblUp, quadUp);

    // ------------------------------------------------------------
    // Index reload and next count
    // ------------------------------------------------------------
    assign idxPhase  = ({syncBus.chA, syncBus.chB} == IDX_PHASE);
    assign idxHit    = indexEn & syncBus.chZ & idxPhase;
    assign countInc  = count_r + 1'b1;
    assign countDec  = count_r - 1'b1;
    assign countStep = stepUp ? countInc : countDec;

    // The index wins over a step in the same cycle so the reload point is exact.
    assign count_nxt = idxHit   ? CNT_ZERO :
                       countEvt ? countStep :
                       count_r;

    // ------------------------------------------------------------
    // Sample capture
    // ------------------------------------------------------------
    assign smpSync_nxt     = {smpSync_r[1:0], sampleClk};
    assign sampleEvt       = smpSync_r[1] & ~smpSync_r[2];
    assign sampleValid_nxt = sampleEvt;
    // The captured value includes a step that lands in the sampling cycle.
    assign sampleCount_nxt = sampleEvt ? count_nxt : sampleCount;
    assign dirUp_nxt       = countEvt ? stepUp : dirUp;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_r <= CNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            smpSync_r <= 3'h0;
        end else begin
            smpSync_r <= smpSync_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sampleValid <= 1'b0;
        end else begin
            sampleValid <= sampleValid_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sampleCount <= CNT_RST;
        end else begin
            sampleCount <= sampleCount_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dirUp <= 1'b1;
        end else begin
            dirUp <= dirUp_nxt;
        end
    end

endmodule

// [qec_enc_model.sv]
`timescale 1ns/1ns
// ----
// Encoder stand-in: Gray phase, one step per request.
// ----
module qec_enc_model (
    input  wire logic core_clk,
    input  wire logic step,
    input  wire logic fwd,
    input  wire logic idxOn,
    output logic      chA,
    output logic      chB,
    output logic      chZ
);
    logic [1:0] phase_r = 2'h0;
    assign chA = phase_r == 2'h1 || phase_r == 2'h2;
    assign chB = phase_r[1];
    // Index shows only at one phase, as a real disc mark would.
    assign chZ = idxOn && phase_r == 2'h2;
    always @(negedge core_clk) begin
        if (step) phase_r <= fwd ? phase_r + 2'h1 : phase_r - 2'h1;
    end
endmodule

// [qec_counter_assertions.sv]
`timescale 1ns/1ns
module qec_counter_assertions
    import qec_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             rst,
    input wire logic             pinA,
    input wire logic             pinB,
    input wire logic             invA,
    input wire logic             invB,
    input wire logic [1:0]       decodeMode,
    input wire logic             sampleClk,
    input wire logic [CNT_W-1:0] sampleCount,
    input wire logic             sampleValid,
    input wire logic             dirUp
);
    // ----
    // Port checks
    // ----
    // Direction checks skip inverted channels, where pin edges swap meaning.
    wire countOn = decodeMode != 2'h3 && !invA && !invB;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_RST: assert property (disable iff (1'b0) rst |=> !sampleValid && dirUp && sampleCount == 0)
        else $error("reset state");
    AST_LAT: assert property ($rose(sampleClk) |-> ##3 sampleValid) else $error("late");
    AST_CAUSE: assert property (sampleValid |-> $past(sampleClk, 3) && !$past(sampleClk, 4))
        else $error("no cause");
    AST_PULSE: assert property (sampleValid |=> !sampleValid) else $error("long");
    AST_HOLD: assert property (!sampleValid |-> $stable(sampleCount)) else $error("drift");
    AST_OFF: assert property ((decodeMode == 2'h3) [*4] |-> $stable(dirUp)) else $error("off");
    AST_ONLY_A: assert property ((decodeMode == 2'h1 && $stable(pinA)) [*5] |-> $stable(dirUp))
        else $error("B counted");
    AST_UP: assert property (countOn && $rose(pinA) && !pinB |-> ##[2:4] dirUp) else $error("up");
    AST_DN: assert property (countOn && $fell(pinA) && !pinB |-> ##[2:4] !dirUp) else $error("dn");
    cover property (sampleValid && decodeMode == 2'h2);
    cover property (sampleValid && sampleCount == 0);
    cover property ($fell(dirUp));
endmodule
bind qec_counter qec_counter_assertions chk (.core_clk, .rst, .pinA, .pinB, .invA, .invB,
    .decodeMode, .sampleClk, .sampleCount, .sampleValid, .dirUp);

// [quadrature_encoder_counter_tb.sv]
`timescale 1ns/1ns
module quadrature_encoder_counter_tb;
    import qec_pkg::*;
    // ----
    // Bench
    // ----
    logic core_clk = 0, rst = 1, step = 0, fwd = 1, idxOn = 0, invA = 0, invB = 0, invZ = 0;
    logic indexEn = 0, sampleClk = 0, chA, chB, chZ, sampleValid, dirUp;
    logic [1:0] decodeMode = 2'h0;
    logic [CNT_W-1:0] sampleCount, expCnt = '0;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    qec_enc_model enc (.core_clk, .step, .fwd, .idxOn, .chA, .chB, .chZ);
    qec_counter uut (.core_clk, .rst, .pinA(chA), .pinB(chB), .pinZ(chZ), .invA, .invB,
        .invZ, .decodeMode, .indexEn, .sampleClk, .sampleCount, .sampleValid, .dirUp);
    initial forever #5 core_clk = ~core_clk;
    // The run needs under 3000 cycles, so this only trips on a hang.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("unexpected at %0t: timeout", $time);
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic move(input int n, input logic up);
        fwd = up;
        repeat (n) begin
            step <= 1;
            @(negedge core_clk);
            step <= 0;
            repeat (4) @(negedge core_clk);
        end
    endtask
    task automatic sample(input logic [CNT_W-1:0] exp, input logic up);
        int k = 0;
        sampleClk = 1;
        while (sampleValid !== 1'b1 && k < 8) begin
            @(posedge core_clk);
            #1 k++;
        end
        check(CNT_W'(sampleValid), CNT_W'(1'b1));
        check(sampleCount, exp);
        check(CNT_W'(dirUp), CNT_W'(up));
        @(negedge core_clk);
        sampleClk = 0;
        repeat (3) @(negedge core_clk);
    endtask
    // Mode is parked at no-count while inversion flips, or the flip would count.
    task automatic cfg(input logic [1:0] m, input logic ia, input logic ib = 1'b0);
        decodeMode = 2'h3;
        repeat (6) @(negedge core_clk);
        invA = ia;
        invB = ib;
        repeat (6) @(negedge core_clk);
        decodeMode = m;
    endtask
    task automatic t_modes();
        cfg(2'h0, 0);
        move(8, 1);
        sample(expCnt + 2, 1);
        move(4, 0);
        sample(expCnt + 1, 0);
        cfg(2'h1, 0);
        move(8, 0);
        sample(expCnt - 3, 0);
        move(4, 1);
        sample(expCnt - 1, 1);
        cfg(2'h2, 0);
        move(4, 0);
        sample(expCnt - 5, 0);
        move(8, 1);
        sample(expCnt + 3, 1);
        cfg(2'h3, 0);
        move(4, 0);
        sample(expCnt + 3, 1);
        cfg(2'h0, 1);
        move(4, 1);
        sample(expCnt + 2, 0);
        cfg(2'h2, 0, 1);
        move(4, 1);
        sample(expCnt - 2, 0);
    endtask
    task automatic t_index();
        cfg(2'h2, 0);
        indexEn = 1;
        idxOn = 1;
        move(2, 1);
        sample(CNT_ZERO, 1);
        move(2, 1);
        sample(CNT_ZERO + 2, 1);
        indexEn = 0;
        move(4, 1);
        sample(CNT_ZERO + 6, 1);
        idxOn = 0;
        invZ = 1;
        indexEn = 1;
        move(2, 1);
        sample(CNT_ZERO, 1);
        indexEn = 0;
        invZ = 0;
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 0;
        @(negedge core_clk);
        sample(CNT_RST, 1);
        sample(CNT_RST, 1);
        t_modes();
        t_index();
        test_done();
    end
endmodule
